//--- hdl/setup_cmd_pkg.sv
/*
  Constants, types and shared decoders for the setup-write / setup-read
  command interpreter.
  Assumes an ASCII serial front end that hands over one received character
  per valid strobe, synchronous to REF_CLK.
*/
package setup_cmd_pkg;

  // ---------------------------------------------------------------------
  // characters of the command line
  // ---------------------------------------------------------------------
  localparam logic [7:0] CHAR_PROMPT = 8'h24; // '$' opens a command
  localparam logic [7:0] CHAR_CR = 8'h0d;     // ends a command
  localparam logic [7:0] LTR_W = 8'h57;
  localparam logic [7:0] LTR_E = 8'h45;
  localparam logic [7:0] LTR_S = 8'h53;
  localparam logic [7:0] LTR_U = 8'h55;
  localparam logic [7:0] LTR_R = 8'h52;
  localparam logic [7:0] LEAD_OK = 8'h2a;     // '*' prompt on success
  localparam logic [7:0] LEAD_ERR = 8'h3f;    // '?' on every error
  localparam logic [7:0] CHAR_SPACE = 8'h20;  // between address and text

  // ---------------------------------------------------------------------
  // operand layout
  // ---------------------------------------------------------------------
  localparam logic [3:0] OPERAND_LEN = 4'h8;  // hex chars in setup-write
  localparam logic [3:0] COUNT_MAX = 4'h9;    // saturates: "too many"
  localparam int ADDR_MSB = 7;                // bit 7 of byte 1
  localparam int BYTE1_HI = 31;               // byte 1 sits at the top
  localparam int BYTE1_LO = 24;
  localparam logic [3:0] COUNT_RST = 4'h0;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  // ---------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,  // waiting for a prompt
    ST_ADDR = 3'b001,  // address character
    ST_CMDH = 3'b011,  // first command letter
    ST_CMDL = 3'b010,  // second command letter
    ST_OPER = 3'b110   // operand until CR
  } parse_state_e;

  typedef enum logic [2:0] {
    CMD_NONE, CMD_UNLOCK, CMD_SWRITE, CMD_SREAD, CMD_BAD
  } cmd_e;

  typedef enum logic [2:0] {
    RSP_OK, RSP_DATA, RSP_SYNTAX, RSP_ADDRESS, RSP_PROTECT, RSP_COMMAND
  } rsp_kind_e;

  typedef struct packed {
    rsp_kind_e kind;    // which answer
    logic [7:0] lead;   // '*' or '?'
    logic [7:0] addr;   // channel address echoed
    logic [7:0] sep;    // space after address on errors
    logic [31:0] data;  // setup bytes on a read
  } rsp_s;

  // ---------------------------------------------------------------------
  // decoders
  // ---------------------------------------------------------------------
  function automatic logic is_hex(input logic [7:0] ch);
    is_hex = (ch >= 8'h30 && ch <= 8'h39) || (ch >= 8'h41 && ch <= 8'h46);
  endfunction : is_hex

  function automatic logic [3:0] hex_val(input logic [7:0] ch);
    if (ch <= 8'h39) begin
      hex_val = ch[3:0];
    end else begin
      hex_val = 4'(ch[3:0] + 4'h9); // 'A'=41 -> a
    end
  endfunction : hex_val

  // reserved codes and anything with bit 7 set are refused
  function automatic logic addr_illegal(input logic [7:0] a);
    addr_illegal = a[ADDR_MSB] || a == 8'h00 || a == 8'h0d ||
                   a == 8'h24 || a == 8'h23 || a == 8'h7b || a == 8'h7d;
  endfunction : addr_illegal

  function automatic cmd_e cmd_decode(input logic [7:0] h,
                                      input logic [7:0] l);
    if (h == LTR_W && l == LTR_E) begin
      cmd_decode = CMD_UNLOCK;
    end else if (h == LTR_S && l == LTR_U) begin
      cmd_decode = CMD_SWRITE;
    end else if (h == LTR_R && l == LTR_S) begin
      cmd_decode = CMD_SREAD;
    end else begin
      cmd_decode = CMD_BAD;
    end
  endfunction : cmd_decode

endpackage : setup_cmd_pkg

//--- hdl/operand_collect.sv
/*
  Operand collector: shifts hex nibbles into a 32-bit word and counts the
  operand characters.
  Assumes the parent clears it before each operand and pushes only while
  an operand is being received.
*/
`timescale 1ns/1ps
module operand_collect
  import setup_cmd_pkg::*;
(
  input wire logic clk,           // module clock
  input wire logic rst_n,         // async reset, active low
  input wire logic clear,         // start of a new operand
  input wire logic push,          // one operand character
  input wire logic [7:0] ch,      // the character
  output logic [31:0] word,       // assembled bytes 1..4
  output logic [3:0] count        // chars seen, saturating
);

  logic [31:0] word_q;  // shift register
  logic [3:0] count_q;  // saturating length

  // ---------------------------------------------------------------------
  // nibble shifter: first char lands in the top nibble after eight
  // ---------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_q <= WORD_RST;
    end else if (clear) begin
      word_q <= WORD_RST;
    end else if (push) begin
      word_q <= {word_q[27:0], hex_val(ch)};
    end
  end

  // ---------------------------------------------------------------------
  // length counter; saturation keeps "too long" visible
  // ---------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= COUNT_RST;
    end else if (clear) begin
      count_q <= COUNT_RST;
    end else if (push && count_q != COUNT_MAX) begin
      count_q <= 4'(count_q + 4'h1);
    end
  end

  assign word = word_q;
  assign count = count_q;

endmodule : operand_collect

//--- hdl/setup_cmd_ctrl.sv
/*
  Setup command interpreter: parses '$' address command operand CR lines,
  handles write-unlock, setup-write and setup-read, and drives the
  nonvolatile setup store.
  Assumes the store shows a written word on NVM_RD_DATA from the cycle
  after NVM_WR_EN, and that a response formatter turns RSP into text.
*/
`timescale 1ns/1ps
module setup_cmd_ctrl
  import setup_cmd_pkg::*;
#(
  parameter logic [7:0] DEFAULT_ADDR = 8'h30  // address in default mode
) (
  input wire logic REF_CLK,              // 100 MHz clock
  input wire logic RST_N,                // async reset, active low
  input wire logic RX_VALID,             // one received char
  input wire logic [7:0] RX_CHAR,        // received char
  input wire logic DEFAULT_MODE,         // fallback address in force
  input wire logic [31:0] NVM_RD_DATA,   // stored setup bytes
  output logic NVM_WR_EN,                // one-cycle store strobe
  output logic [31:0] NVM_WR_DATA,       // bytes to store
  output logic RSP_VALID,                // one-cycle answer strobe
  output rsp_s RSP                       // answer contents
);

  // ---------------------------------------------------------------------
  // state and working signals
  // ---------------------------------------------------------------------
  parse_state_e state_q;   // parser position
  parse_state_e state_d;
  logic [7:0] cmd_hi_q;    // first command letter
  cmd_e cmd_q;             // decoded command
  logic unlock_q;          // write-unlock armed
  logic nvm_we_q;          // store strobe
  logic [31:0] nvm_wd_q;   // store data
  logic rsp_valid_q;       // answer strobe
  rsp_s rsp_q;             // answer register
  logic [7:0] my_addr;     // address this module answers to
  logic [31:0] op_word;    // collected operand
  logic [3:0] op_count;    // operand length
  logic op_clear;          // new operand starts
  logic op_push;           // operand character taken
  logic at_cr;             // CR closes the operand
  logic abort;             // non-hex inside a setup-write
  logic fire;              // an answer is due this cycle
  rsp_kind_e verdict;      // the answer's kind

  // fallback address keeps a lost module reachable
  assign my_addr = DEFAULT_MODE ? DEFAULT_ADDR
                 : NVM_RD_DATA[BYTE1_HI:BYTE1_LO];

  assign at_cr = RX_VALID && state_q == ST_OPER && RX_CHAR == CHAR_CR;
  assign abort = RX_VALID && state_q == ST_OPER && RX_CHAR != CHAR_CR &&
                 cmd_q == CMD_SWRITE && !is_hex(RX_CHAR);
  assign op_clear = RX_VALID && state_q == ST_CMDL;
  assign op_push = RX_VALID && state_q == ST_OPER && !at_cr && !abort;
  assign fire = at_cr || abort;

  operand_collect u_collect (
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .clear (op_clear),
    .push  (op_push),
    .ch    (RX_CHAR),
    .word  (op_word),
    .count (op_count)
  );

  // ---------------------------------------------------------------------
  // verdict: whole operand is judged before anything is committed
  // ---------------------------------------------------------------------
  always_comb begin
    verdict = RSP_SYNTAX;
    if (abort) begin
      verdict = RSP_SYNTAX;
    end else begin
      case (cmd_q)
        CMD_UNLOCK: begin
          verdict = (op_count == COUNT_RST) ? RSP_OK : RSP_SYNTAX;
        end
        CMD_SREAD: begin
          verdict = (op_count == COUNT_RST) ? RSP_DATA : RSP_SYNTAX;
        end
        CMD_SWRITE: begin
          if (op_count != OPERAND_LEN) begin
            verdict = RSP_SYNTAX;
          end else if (!unlock_q) begin
            verdict = RSP_PROTECT;
          end else if (addr_illegal(op_word[BYTE1_HI:BYTE1_LO])) begin
            verdict = RSP_ADDRESS;
          end else begin
            verdict = RSP_OK;
          end
        end
        default: begin
          verdict = RSP_COMMAND;                   // unknown command
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // line parser; foreign addresses drop back to idle silently
  // ---------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    if (RX_VALID) begin
      case (state_q)
        ST_IDLE: begin
          if (RX_CHAR == CHAR_PROMPT) begin
            state_d = ST_ADDR;
          end
        end
        ST_ADDR: begin
          // a stale address no longer matches after a rewrite
          state_d = (RX_CHAR == my_addr) ? ST_CMDH : ST_IDLE;
        end
        ST_CMDH: begin
          state_d = (RX_CHAR == CHAR_CR) ? ST_IDLE : ST_CMDL;
        end
        ST_CMDL: begin
          state_d = (RX_CHAR == CHAR_CR) ? ST_IDLE : ST_OPER;
        end
        ST_OPER: begin
          if (fire) begin
            state_d = ST_IDLE;
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // command letters; a CR as second letter never reaches ST_OPER
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cmd_hi_q <= 8'h00;
      cmd_q <= CMD_NONE;
    end else if (RX_VALID && state_q == ST_CMDH) begin
      cmd_hi_q <= RX_CHAR;
    end else if (op_clear) begin
      cmd_q <= cmd_decode(cmd_hi_q, RX_CHAR);
    end
  end

  // ---------------------------------------------------------------------
  // write-unlock: other errors keep it so the user may retry
  // ---------------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      unlock_q <= 1'b0;
    end else if (fire && cmd_q == CMD_UNLOCK && verdict == RSP_OK) begin
      unlock_q <= 1'b1;
    end else if (fire && (verdict == RSP_OK || verdict == RSP_DATA ||
                          verdict == RSP_PROTECT)) begin
      unlock_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // nonvolatile commit, only after a clean verdict
  // ---------------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      nvm_we_q <= 1'b0;
      nvm_wd_q <= WORD_RST;
    end else begin
      nvm_we_q <= fire && cmd_q == CMD_SWRITE && verdict == RSP_OK;
      if (fire && cmd_q == CMD_SWRITE && verdict == RSP_OK) begin
        nvm_wd_q <= op_word;
      end
    end
  end

  // ---------------------------------------------------------------------
  // answer register; carries the address in force when the line arrived
  // ---------------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rsp_valid_q <= 1'b0;
      rsp_q <= '0;
    end else begin
      rsp_valid_q <= fire;
      if (fire) begin
        rsp_q.kind <= verdict;
        rsp_q.addr <= my_addr;
        rsp_q.data <= (verdict == RSP_DATA) ? NVM_RD_DATA
                                            : WORD_RST;
        if (verdict == RSP_OK || verdict == RSP_DATA) begin
          rsp_q.lead <= LEAD_OK;
          rsp_q.sep <= 8'h00;
        end else begin
          rsp_q.lead <= LEAD_ERR;
          rsp_q.sep <= CHAR_SPACE;
        end
      end
    end
  end

  assign NVM_WR_EN = nvm_we_q;
  assign NVM_WR_DATA = nvm_wd_q;
  assign RSP_VALID = rsp_valid_q;
  assign RSP = rsp_q;

  // ---------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  sequence s_swrite_end;
    fire && cmd_q == CMD_SWRITE;
  endsequence

  sequence s_unlock_ok;
    fire && cmd_q == CMD_UNLOCK && verdict == RSP_OK;
  endsequence

  AST_WRITE_NEEDS_UNLOCK: assert property (
    $rose(NVM_WR_EN) |-> $past(unlock_q))
    else $error("store written without unlock");

  AST_WRITE_LEN: assert property (
    NVM_WR_EN |-> $past(op_count) == OPERAND_LEN)
    else $error("store written with wrong operand length");

  AST_WRITE_ADDR_LEGAL: assert property (
    NVM_WR_EN |-> !addr_illegal(NVM_WR_DATA[BYTE1_HI:BYTE1_LO]))
    else $error("illegal address committed");

  AST_UNLOCK_CLEARS: assert property (
    s_swrite_end ##0 (verdict == RSP_OK) |=> !unlock_q ##1 !unlock_q)
    else $error("unlock not cleared after write");

  AST_UNLOCK_ARMS: assert property (
    s_unlock_ok |=> unlock_q)
    else $error("unlock not armed");

  AST_ABORT_SYNTAX: assert property (
    abort |=> RSP_VALID && RSP.kind == RSP_SYNTAX && !NVM_WR_EN)
    else $error("abort did not give syntax error");

  AST_ERR_LEAD: assert property (
    RSP_VALID && RSP.kind != RSP_OK && RSP.kind != RSP_DATA |->
      RSP.lead == LEAD_ERR && RSP.sep == CHAR_SPACE)
    else $error("error answer lacks lead mark");

  AST_READ_DATA: assert property (
    fire && verdict == RSP_DATA |=> RSP_VALID &&
      RSP.data == $past(NVM_RD_DATA))
    else $error("read answer does not carry stored bytes");

  AST_FOREIGN_ADDR: assert property (
    RX_VALID && state_q == ST_ADDR && RX_CHAR != my_addr |=>
      state_q == ST_IDLE && !RSP_VALID)
    else $error("foreign address not ignored");

  AST_REJECT_NO_WRITE: assert property (
    s_swrite_end ##0 (verdict != RSP_OK) |=> !NVM_WR_EN)
    else $error("rejected write reached the store");

endmodule : setup_cmd_ctrl

//--- verification/setup_store_model.sv
/*
  Behavioural model of the nonvolatile setup store beside the interpreter.
  Assumes one clock; a written word shows on NVM_RD_DATA the cycle after
  the store strobe, and the contents survive any reset of the interpreter.
*/
`timescale 1ns/1ps
module setup_store_model #(
  parameter logic [31:0] INIT_WORD = 32'h3107_0080 // contents at power-up
) (
  input wire logic REF_CLK,            // module clock
  input wire logic NVM_WR_EN,          // store strobe
  input wire logic [31:0] NVM_WR_DATA, // bytes to store
  output logic [31:0] NVM_RD_DATA      // stored bytes
);
  // ---------------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------------
  // no reset on purpose: the word must outlive a reset of the interpreter
  initial NVM_RD_DATA = INIT_WORD;
  // take the word on the strobe, visible from the next cycle
  always @(posedge REF_CLK) begin
    if (NVM_WR_EN === 1'b1) begin
      NVM_RD_DATA <= NVM_WR_DATA;
    end
  end
endmodule : setup_store_model

//--- verification/testbench.sv
/*
  Self-checking bench for the setup command interpreter: plays the host,
  notes each expected answer in a queue and checks answers as they come.
  Assumes the store model of setup_store_model.sv and the package.
*/
`timescale 1ns/1ps
module testbench;
  import setup_cmd_pkg::*;
  // ---------------------------------------------------------------------
  // signals and bookkeeping
  // ---------------------------------------------------------------------
  typedef struct packed {
    rsp_s r;         // expected answer
    logic wr;        // store strobe expected with it
    logic [31:0] wd; // expected stored word
  } note_s;
  localparam logic [7:0] DFLT = 8'h30; // fallback address
  logic REF_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic RX_VALID = 1'b0;
  logic [7:0] RX_CHAR = 8'h00;
  logic DEFAULT_MODE = 1'b0;
  logic [31:0] NVM_RD_DATA;
  logic NVM_WR_EN;
  logic [31:0] NVM_WR_DATA;
  logic RSP_VALID;
  rsp_s RSP;
  int n_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h0000_000c; // xorshift state
  logic [7:0] line_q[$];             // characters of the next line
  note_s notes[$];                   // answers still awaited
  logic [7:0] cur_addr;              // address in force
  logic [31:0] stored;               // word the store should hold
  logic [31:0] w;
  logic [7:0] bad[8] = '{8'h00, 8'h0d, 8'h24, 8'h23, 8'h7b, 8'h7d,
                         8'h80, 8'hb1};

  always #5 REF_CLK = ~REF_CLK;

  setup_cmd_ctrl #(.DEFAULT_ADDR(DFLT)) i_setup_cmd_ctrl (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .RX_VALID(RX_VALID),
    .RX_CHAR(RX_CHAR), .DEFAULT_MODE(DEFAULT_MODE),
    .NVM_RD_DATA(NVM_RD_DATA), .NVM_WR_EN(NVM_WR_EN),
    .NVM_WR_DATA(NVM_WR_DATA), .RSP_VALID(RSP_VALID), .RSP(RSP));
  setup_store_model i_setup_store_model (
    .REF_CLK(REF_CLK), .NVM_WR_EN(NVM_WR_EN),
    .NVM_WR_DATA(NVM_WR_DATA), .NVM_RD_DATA(NVM_RD_DATA));

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic check_rsp(input string what, input rsp_s e, input rsp_s g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask : check_rsp

  task automatic check_val(input string what, input logic [31:0] e,
                           input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask : check_val

  // lead, separator and data follow from the kind
  task automatic note_rsp(input rsp_kind_e k, input logic [31:0] d,
                          input logic wr);
    note_s n;
    n.r.kind = k;
    n.r.lead = (k == RSP_OK || k == RSP_DATA) ? LEAD_OK : LEAD_ERR;
    n.r.addr = cur_addr;
    n.r.sep = (k == RSP_OK || k == RSP_DATA) ? 8'h00 : CHAR_SPACE;
    n.r.data = (k == RSP_DATA) ? d : 32'h0;
    n.wr = wr;
    n.wd = d;
    notes.push_back(n);
  endtask : note_rsp

  task automatic head(input logic [7:0] a, input string s);
    line_q.push_back(CHAR_PROMPT);
    line_q.push_back(a);
    for (int i = 0; i < s.len(); i++) line_q.push_back(s[i]);
  endtask : head

  // one char per edge, back to back, then wait for the answer
  task automatic send();
    foreach (line_q[i]) begin
      RX_VALID <= 1'b1;
      RX_CHAR <= line_q[i];
      @(posedge REF_CLK);
    end
    RX_VALID <= 1'b0;
    line_q.delete();
    for (int i = 0; i < 20 && notes.size() != 0; i++) @(posedge REF_CLK);
    @(posedge REF_CLK);
  endtask : send

  task automatic line(input logic [7:0] a, input string s);
    head(a, s);
    line_q.push_back(CHAR_CR);
    send();
  endtask : line

  // upper-case hex, high nibble first; len 7 or 9 bends the length
  task automatic su(input logic [31:0] v, input int len);
    logic [3:0] nib;
    head(cur_addr, "SU");
    for (int i = 7; i >= 0; i--) begin
      nib = v[4*i+:4];
      line_q.push_back((nib < 4'ha) ? {4'h0, nib} + 8'h30
                                    : {4'h0, nib} + 8'h37);
    end
    if (len < 8) void'(line_q.pop_back());
    if (len > 8) line_q.push_back(8'h30);
    line_q.push_back(CHAR_CR);
    send();
  endtask : su

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  // ---------------------------------------------------------------------
  // answer monitor and timeout
  // ---------------------------------------------------------------------
  // sampled mid-cycle so the registered outputs have settled
  always @(negedge REF_CLK) begin
    note_s n;
    if (RSP_VALID === 1'b1) begin
      if (notes.size() == 0) begin
        n_errors++;
        $display("unexpected RSP: expected none seen %h", RSP);
      end else begin
        n = notes.pop_front();
        check_rsp("RSP", n.r, RSP);
        check_val("NVM_WR_EN", {31'h0, n.wr}, {31'h0, NVM_WR_EN});
        if (n.wr) check_val("NVM_WR_DATA", n.wd, NVM_WR_DATA);
      end
    end else if (NVM_WR_EN !== 1'b0) begin
      n_errors++;
      $display("unexpected NVM_WR_EN: expected 0 seen %b", NVM_WR_EN);
    end
  end

  // the whole run needs about 310 cycles
  always @(posedge REF_CLK) begin
    cycles++;
    if (cycles == 6000) begin
      n_errors++;
      $display("unexpected timeout: expected end seen %0d cycles", cycles);
      test_done();
    end
  end

  // ---------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------
  initial begin
    cur_addr = 8'h31;
    stored = 32'h3107_0080;
    repeat (12) @(posedge REF_CLK);
    RST_N <= 1'b1;
    @(posedge REF_CLK);
    note_rsp(RSP_DATA, stored, 1'b0);
    line(cur_addr, "RS");
    note_rsp(RSP_PROTECT, stored, 1'b0);
    su(stored, 8);
    $display("test read and protect done");
    note_rsp(RSP_OK, 32'h0, 1'b0);
    line(cur_addr, "WE");
    note_rsp(RSP_SYNTAX, 32'h0, 1'b0);
    su(stored, 7);
    note_rsp(RSP_SYNTAX, 32'h0, 1'b0);
    su(stored, 9);
    // every reserved code, and bit 7 set, refused with nothing stored
    foreach (bad[i]) begin
      w = rnd();
      w[31:24] = bad[i];
      note_rsp(RSP_ADDRESS, 32'h0, 1'b0);
      su(w, 8);
    end
    note_rsp(RSP_SYNTAX, 32'h0, 1'b0);
    head(cur_addr, "SU3107X");
    line_q.push_back(CHAR_CR);
    send();
    // unlock survived the errors above, so this write must land
    w = rnd();
    w[31:24] = 8'h31;
    note_rsp(RSP_OK, w, 1'b1);
    su(w, 8);
    stored = w;
    note_rsp(RSP_PROTECT, 32'h0, 1'b0);
    su(w, 8);
    note_rsp(RSP_DATA, stored, 1'b0);
    line(cur_addr, "RS");
    $display("test operand checks done");
    note_rsp(RSP_OK, 32'h0, 1'b0);
    line(cur_addr, "WE");
    w = rnd();
    w[31:24] = 8'h32;
    note_rsp(RSP_OK, w, 1'b1);
    su(w, 8);
    stored = w;
    cur_addr = 8'h32;
    line(8'h31, "RS");
    note_rsp(RSP_DATA, stored, 1'b0);
    line(cur_addr, "RS");
    note_rsp(RSP_COMMAND, 32'h0, 1'b0);
    line(cur_addr, "ZZ");
    note_rsp(RSP_SYNTAX, 32'h0, 1'b0);
    line(cur_addr, "WE1");
    $display("test address change done");
    DEFAULT_MODE <= 1'b1;
    @(posedge REF_CLK);
    cur_addr = DFLT;
    note_rsp(RSP_DATA, stored, 1'b0);
    line(DFLT, "RS");
    DEFAULT_MODE <= 1'b0;
    @(posedge REF_CLK);
    cur_addr = 8'h32;
    $display("test default mode done");
    // a reset in mid-run must not lose the stored word
    RST_N <= 1'b0;
    repeat (2) @(posedge REF_CLK);
    RST_N <= 1'b1;
    @(posedge REF_CLK);
    note_rsp(RSP_DATA, stored, 1'b0);
    line(cur_addr, "RS");
    check_val("pending answers", 32'h0, notes.size());
    $display("test reset retention done");
    test_done();
  end
endmodule : testbench
